// ===== hw/scr_pkg.sv
// Package with register map, field layout, reset values and carrier types of the SCSI core.
package scr_pkg;

	// ==========================================================================
	// Register offsets, in bytes from the base address.
	// ==========================================================================
	localparam logic [5:0] OFF_COUNT_LOW     = 6'h00;
	localparam logic [5:0] OFF_COUNT_MID     = 6'h04;
	localparam logic [5:0] OFF_FIFO_PORT     = 6'h08;
	localparam logic [5:0] OFF_COMMAND       = 6'h0c;
	localparam logic [5:0] OFF_STATUS_ID     = 6'h10;
	localparam logic [5:0] OFF_INT_TIMEOUT   = 6'h14;
	localparam logic [5:0] OFF_STATE_PERIOD  = 6'h18;
	localparam logic [5:0] OFF_FIFO_OFFSET   = 6'h1c;
	localparam logic [5:0] OFF_CONTROL_ONE   = 6'h20;
	localparam logic [5:0] OFF_CLOCK_CONV    = 6'h24;
	localparam logic [5:0] OFF_RESERVED_A    = 6'h28;
	localparam logic [5:0] OFF_CONTROL_TWO   = 6'h2c;
	localparam logic [5:0] OFF_CONTROL_THREE = 6'h30;
	localparam logic [5:0] OFF_CONTROL_FOUR  = 6'h34;
	localparam logic [5:0] OFF_COUNT_HIGH    = 6'h38;
	localparam logic [5:0] OFF_RESERVED_B    = 6'h3c;

	// Bits of the bus address that select a register inside the window.
	localparam int WINDOW_BITS = 6;
	// Base address register in configuration space.
	localparam logic [7:0] CFG_BASE_OFFSET = 8'h10;

	// ==========================================================================
	// Field layout and masks of the writable registers.
	// ==========================================================================
	localparam logic [7:0] MASK_TARGET_ID   = 8'h07;
	localparam logic [7:0] MASK_SYNC_PERIOD = 8'h1f;
	localparam logic [7:0] MASK_CONTROL_ONE = 8'hd7;
	localparam logic [7:0] MASK_CLOCK_CONV  = 8'h07;
	localparam logic [7:0] MASK_CONTROL_TWO = 8'h40;
	localparam logic [7:0] MASK_CONTROL_THR = 8'h98;
	localparam logic [7:0] MASK_CONTROL_FOU = 8'he4;
	localparam int         BIT_ENABLE_FEAT  = 6;
	localparam int         BIT_SYNC_FLAG    = 3;
	localparam int         LSB_FIFO_ISTATE  = 5;

	// ==========================================================================
	// Reset values.
	// ==========================================================================
	localparam logic [7:0] RST_SYNC_PERIOD = 8'h05;
	localparam logic [7:0] RST_CLOCK_CONV  = 8'h02;
	localparam logic [7:0] RST_SYNC_OFFSET = 8'h00;
	localparam logic [7:0] RST_CONTROL     = 8'h00;

	// ==========================================================================
	// Carrier types.
	// ==========================================================================
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} scr_bus_req_t;

	typedef struct packed {
		logic [7:0] bus_status;
		logic [7:0] int_status;
		logic [2:0] seq_state;
		logic       sync_flag;
		logic [4:0] fifo_count;
		logic [2:0] fifo_istate;
		logic [7:0] fifo_rdata;
		logic [7:0] cmd_current;
	} scr_core_stat_t;

	typedef struct packed {
		logic [2:0] target_id;
		logic [7:0] sel_timeout;
		logic [4:0] sync_period;
		logic [7:0] sync_offset_timing;
		logic [7:0] control_one;
		logic [2:0] clock_conv;
		logic [7:0] control_two;
		logic [7:0] control_three;
		logic [7:0] control_four;
	} scr_cfg_t;

endpackage

// ===== hw/scr_xfer_counter.sv
// Transfer counter of the SCSI core: start value, current value, decrement.
`timescale 1ns/10ps
`default_nettype none

module scr_xfer_counter #(
	parameter int WIDTH = 24
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic             wide_en,
	input  wire logic [2:0]       byte_wr,
	input  wire logic [7:0]       byte_data,
	input  wire logic             load,
	input  wire logic             dec_byte,
	input  wire logic             dec_word,
	output logic      [WIDTH-1:0] current_count,
	output logic                  count_zero
);
	import scr_pkg::*;

	logic [WIDTH-1:0] start_reg;
	logic [WIDTH-1:0] current_reg;
	logic [WIDTH-1:0] current_next;
	logic [WIDTH-1:0] step;
	logic [WIDTH-1:0] width_mask;

	// ==========================================================================
	// Start value: kept through reset so repeated transfers need no rewrite.
	// ==========================================================================
	always_ff @(posedge mclk) begin
		if (byte_wr[0]) begin
			start_reg[7:0] <= byte_data;
		end
		if (byte_wr[1]) begin
			start_reg[15:8] <= byte_data;
		end
		if (byte_wr[2] && wide_en) begin
			start_reg[WIDTH-1:16] <= byte_data[WIDTH-17:0];
		end
	end

	// ==========================================================================
	// Current value: loaded at command start, counts down to zero.
	// ==========================================================================
	assign width_mask = wide_en ? {WIDTH{1'b1}} : {{(WIDTH-16){1'b0}}, 16'hffff};
	assign step       = dec_word ? WIDTH'(2) : (dec_byte ? WIDTH'(1) : '0);

	always_comb begin
		current_next = current_reg;
		if (load) begin
			current_next = start_reg & width_mask;
		end else if (step > current_reg) begin
			current_next = '0;
		end else begin
			current_next = (current_reg - step) & width_mask;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			current_reg <= '0;
		end else begin
			current_reg <= current_next;
		end
	end

	assign current_count = current_reg;
	assign count_zero    = (current_reg == '0);

endmodule // scr_xfer_counter

`default_nettype wire

// ===== hw/scr_regs.sv
// Register map and address decode of the SCSI core.
// ============================================================================
// Summary of operation
// - Data in lowest byte lane only.
// - Decode offsets from configured base address.
// - Count bytes at 0x00, 0x04, 0x38.
// - 0x38 read gives count high or ID.
// - 0x10 and 0x14 split by direction.
// - 0x18 reads state, writes sync period.
// - 0x1C reads FIFO level, writes offset timing.
// - Reset loads period 5, factor 2, offset 0.
// - High count byte needs enable-features bit.
`timescale 1ns/10ps
`default_nettype none

module scr_regs #(
	parameter logic [7:0] PART_ID     = 8'h5a, // Arbitrary identification value.
	parameter int         COUNT_WIDTH = 24
) (
	input  wire logic                    mclk,
	input  wire logic                    rst_b,
	input  wire logic [31:0]             base_addr,
	input  wire scr_pkg::scr_bus_req_t   bus_req,
	output logic      [31:0]             bus_rdata,
	output logic                         bus_rvalid,
	input  wire scr_pkg::scr_core_stat_t core_stat,
	input  wire logic                    dma_start,
	input  wire logic                    dec_byte,
	input  wire logic                    dec_word,
	output logic                         count_zero,
	output logic      [COUNT_WIDTH-1:0]  current_count,
	output scr_pkg::scr_cfg_t            cfg,
	output logic                         fifo_push,
	output logic                         fifo_pop,
	output logic      [7:0]              fifo_wdata,
	output logic                         cmd_push,
	output logic      [7:0]              cmd_wdata,
	output logic                         int_status_read
);
	import scr_pkg::*;

	// ==========================================================================
	// Decode.
	// ==========================================================================
	logic                   hit;
	logic [5:0]             off;
	logic                   wr_lane0;
	logic                   rd_any;
	logic                   wide_en;
	logic                   id_shown_reg;
	logic [2:0]             cnt_byte_wr;
	logic [7:0]             rd_byte;

	logic [2:0]             target_id_reg;
	logic [7:0]             sel_timeout_reg;
	logic [4:0]             sync_period_reg;
	logic [7:0]             sync_offset_reg;
	logic [7:0]             control_one_reg;
	logic [2:0]             clock_conv_reg;
	logic [7:0]             control_two_reg;
	logic [7:0]             control_three_reg;
	logic [7:0]             control_four_reg;

	// Compares the register-select bits of an address with a fixed offset.
	function automatic logic at_off(input logic [5:0] a, input logic [5:0] o);
		return (a[5:2] == o[5:2]);
	endfunction

	// Base address bits below the window are ignored, so the base is taken as
	// aligned to a 64-byte window.
	assign hit      = (bus_req.addr[31:WINDOW_BITS] == base_addr[31:WINDOW_BITS]);
	assign off      = bus_req.addr[WINDOW_BITS-1:0];
	assign wr_lane0 = bus_req.wr && hit && bus_req.be[0];
	assign rd_any   = bus_req.rd && hit;
	assign wide_en  = control_two_reg[BIT_ENABLE_FEAT];

	assign cnt_byte_wr = {wr_lane0 && at_off(off, OFF_COUNT_HIGH),
			wr_lane0 && at_off(off, OFF_COUNT_MID),
			wr_lane0 && at_off(off, OFF_COUNT_LOW)};

	// ==========================================================================
	// Transfer counter.
	// ==========================================================================
	scr_xfer_counter #(
		.WIDTH(COUNT_WIDTH)
	) u_counter (
		.mclk         (mclk),
		.rst_b        (rst_b),
		.wide_en      (wide_en),
		.byte_wr      (cnt_byte_wr),
		.byte_data    (bus_req.wdata[7:0]),
		.load         (dma_start),
		.dec_byte     (dec_byte),
		.dec_word     (dec_word),
		.current_count(current_count),
		.count_zero   (count_zero)
	);

	// The identification code stands at 0x38 from reset until the high byte
	// is first written; a write ignored because the wide count is off
	// leaves it standing.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			id_shown_reg <= 1'b1;
		end else if (cnt_byte_wr[2] && wide_en) begin
			id_shown_reg <= 1'b0;
		end
	end

	// ==========================================================================
	// Write-only and read/write control registers.
	// ==========================================================================
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			target_id_reg   <= 3'h0;
			sel_timeout_reg <= RST_CONTROL;
		end else if (wr_lane0) begin
			if (at_off(off, OFF_STATUS_ID)) begin
				target_id_reg <= bus_req.wdata[2:0] & MASK_TARGET_ID[2:0];
			end
			if (at_off(off, OFF_INT_TIMEOUT)) begin
				sel_timeout_reg <= bus_req.wdata[7:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sync_period_reg <= RST_SYNC_PERIOD[4:0];
			sync_offset_reg <= RST_SYNC_OFFSET;
			clock_conv_reg  <= RST_CLOCK_CONV[2:0];
		end else if (wr_lane0) begin
			if (at_off(off, OFF_STATE_PERIOD)) begin
				sync_period_reg <= bus_req.wdata[4:0] & MASK_SYNC_PERIOD[4:0];
			end
			if (at_off(off, OFF_FIFO_OFFSET)) begin
				sync_offset_reg <= bus_req.wdata[7:0];
			end
			if (at_off(off, OFF_CLOCK_CONV)) begin
				clock_conv_reg <= bus_req.wdata[2:0] & MASK_CLOCK_CONV[2:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			control_one_reg   <= RST_CONTROL;
			control_two_reg   <= RST_CONTROL;
			control_three_reg <= RST_CONTROL;
			control_four_reg  <= RST_CONTROL;
		end else if (wr_lane0) begin
			if (at_off(off, OFF_CONTROL_ONE)) begin
				control_one_reg <= bus_req.wdata[7:0] & MASK_CONTROL_ONE;
			end
			if (at_off(off, OFF_CONTROL_TWO)) begin
				control_two_reg <= bus_req.wdata[7:0] & MASK_CONTROL_TWO;
			end
			if (at_off(off, OFF_CONTROL_THREE)) begin
				control_three_reg <= bus_req.wdata[7:0] & MASK_CONTROL_THR;
			end
			if (at_off(off, OFF_CONTROL_FOUR)) begin
				control_four_reg <= bus_req.wdata[7:0] & MASK_CONTROL_FOU;
			end
		end
	end

	always_comb begin
		cfg                    = '0;
		cfg.target_id          = target_id_reg;
		cfg.sel_timeout        = sel_timeout_reg;
		cfg.sync_period        = sync_period_reg;
		cfg.sync_offset_timing = sync_offset_reg;
		cfg.control_one        = control_one_reg;
		cfg.clock_conv         = clock_conv_reg;
		cfg.control_two        = control_two_reg;
		cfg.control_three      = control_three_reg;
		cfg.control_four       = control_four_reg;
	end

	// ==========================================================================
	// Read multiplexer.
	// ==========================================================================
	always_comb begin
		rd_byte = 8'h00;
		unique case (off[5:2])
			OFF_COUNT_LOW[5:2]: begin
				rd_byte = current_count[7:0];
			end
			OFF_COUNT_MID[5:2]: begin
				rd_byte = current_count[15:8];
			end
			OFF_FIFO_PORT[5:2]: begin
				rd_byte = core_stat.fifo_rdata;
			end
			OFF_COMMAND[5:2]: begin
				rd_byte = core_stat.cmd_current;
			end
			OFF_STATUS_ID[5:2]: begin
				rd_byte = core_stat.bus_status;
			end
			OFF_INT_TIMEOUT[5:2]: begin
				rd_byte = core_stat.int_status;
			end
			OFF_STATE_PERIOD[5:2]: begin
				rd_byte = {4'h0, core_stat.sync_flag, core_stat.seq_state};
			end
			OFF_FIFO_OFFSET[5:2]: begin
				rd_byte = {core_stat.fifo_istate, core_stat.fifo_count};
			end
			OFF_CONTROL_ONE[5:2]: begin
				rd_byte = control_one_reg;
			end
			OFF_CONTROL_TWO[5:2]: begin
				rd_byte = control_two_reg;
			end
			OFF_CONTROL_THREE[5:2]: begin
				rd_byte = control_three_reg;
			end
			OFF_CONTROL_FOUR[5:2]: begin
				rd_byte = control_four_reg;
			end
			OFF_COUNT_HIGH[5:2]: begin
				rd_byte = id_shown_reg ? PART_ID : current_count[COUNT_WIDTH-1:16];
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// Read data is registered: it answers one cycle after the request.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bus_rdata  <= 32'h0000_0000;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= rd_any;
			if (rd_any) begin
				bus_rdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// ==========================================================================
	// Side effects towards the FIFO, command queue and interrupt logic.
	// ==========================================================================
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			fifo_push       <= 1'b0;
			fifo_pop        <= 1'b0;
			fifo_wdata      <= 8'h00;
			cmd_push        <= 1'b0;
			cmd_wdata       <= 8'h00;
			int_status_read <= 1'b0;
		end else begin
			fifo_push       <= wr_lane0 && at_off(off, OFF_FIFO_PORT);
			fifo_pop        <= rd_any && at_off(off, OFF_FIFO_PORT);
			cmd_push        <= wr_lane0 && at_off(off, OFF_COMMAND);
			int_status_read <= rd_any && at_off(off, OFF_INT_TIMEOUT);
			if (wr_lane0) begin
				fifo_wdata <= bus_req.wdata[7:0];
				cmd_wdata  <= bus_req.wdata[7:0];
			end
		end
	end

endmodule // scr_regs

`default_nettype wire

// ===== verif/scr_host_model.sv
// Host model that issues single register cycles on the request carrier.
`timescale 1ns/10ps
`default_nettype none

module scr_host_model (
	input  wire logic             mclk,
	output var scr_pkg::scr_bus_req_t req
);
	import scr_pkg::*;

	initial req = '0;

	// ==========================================================================
	// Access cycle.
	// ==========================================================================
	// The request stands through the edge that takes it, then drops, so every
	// access leaves one idle cycle and no signal is assigned twice in a step.
	task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d,
			input logic [3:0] be);
		@(posedge mclk) #1;
		req = '{rd: !w, wr: w, addr: a, wdata: {24'h000000, d}, be: be};
		@(posedge mclk) #1;
		req = '0;
	endtask
endmodule // scr_host_model

`default_nettype wire

// ===== verif/scr_regs_props.sv
// Checker of the register map at the ports of its top module.
`timescale 1ns/10ps
`default_nettype none

module scr_regs_props #(
	parameter int COUNT_WIDTH = 24
) (
	input wire logic                    mclk,
	input wire logic                    rst_b,
	input wire logic [31:0]             base_addr,
	input wire scr_pkg::scr_bus_req_t   bus_req,
	input wire logic [31:0]             bus_rdata,
	input wire logic                    bus_rvalid,
	input wire scr_pkg::scr_core_stat_t core_stat,
	input wire logic                    dma_start,
	input wire logic [COUNT_WIDTH-1:0]  current_count,
	input wire scr_pkg::scr_cfg_t       cfg
);
	import scr_pkg::*;

	logic       hit;
	logic       rd_hit;
	logic       wr_hit;
	logic [5:0] off;

	assign hit = bus_req.addr[31:6] == base_addr[31:6];
	assign rd_hit = bus_req.rd && hit;
	assign wr_hit = bus_req.wr && bus_req.be[0] && hit;
	assign off = {bus_req.addr[5:2], 2'b00};

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	// ==========================================================================
	// Properties.
	// ==========================================================================
	property p_lanes;
		bus_rvalid |-> bus_rdata[31:8] == 24'h000000;
	endproperty
	a_lanes: assert property (p_lanes) else $error("upper lanes set");
	property p_answer;
		rd_hit |=> bus_rvalid;
	endproperty
	a_answer: assert property (p_answer) else $error("read unanswered");
	property p_silent;
		!rd_hit |=> !bus_rvalid;
	endproperty
	a_silent: assert property (p_silent) else $error("stray answer");
	property p_count;
		rd_hit && off == OFF_COUNT_LOW |=> bus_rdata[7:0] == $past(current_count[7:0]);
	endproperty
	a_count: assert property (p_count) else $error("count byte wrong");
	property p_status;
		rd_hit && off == OFF_STATUS_ID |=> bus_rdata[7:0] == $past(core_stat.bus_status);
	endproperty
	a_status: assert property (p_status) else $error("status wrong");
	property p_tid;
		wr_hit && off == OFF_STATUS_ID |=> cfg.target_id == $past(bus_req.wdata[2:0]);
	endproperty
	a_tid: assert property (p_tid) else $error("target id wrong");
	property p_state;
		rd_hit && off == OFF_STATE_PERIOD |=>
			bus_rdata[7:0] == {4'h0, $past(core_stat.sync_flag), $past(core_stat.seq_state)};
	endproperty
	a_state: assert property (p_state) else $error("state wrong");
	property p_fifo;
		rd_hit && off == OFF_FIFO_OFFSET |=>
			bus_rdata[7:0] == {$past(core_stat.fifo_istate), $past(core_stat.fifo_count)};
	endproperty
	a_fifo: assert property (p_fifo) else $error("fifo level wrong");
	property p_rsvd;
		rd_hit && (off == OFF_RESERVED_A || off == OFF_RESERVED_B) |=> bus_rdata == 32'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
	property p_reset;
		$rose(rst_b) |-> cfg.sync_period == 5'h05 && cfg.clock_conv == 3'h2
			&& cfg.sync_offset_timing == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset values wrong");
	property p_narrow;
		dma_start && !cfg.control_two[BIT_ENABLE_FEAT] |=> current_count[COUNT_WIDTH-1:16] == '0;
	endproperty
	a_narrow: assert property (p_narrow) else $error("high byte loaded");
endmodule // scr_regs_props

bind scr_regs scr_regs_props #(.COUNT_WIDTH(COUNT_WIDTH)) u_props (.mclk, .rst_b, .base_addr,
	.bus_req, .bus_rdata, .bus_rvalid, .core_stat, .dma_start, .current_count, .cfg);

`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench of the register map.
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import scr_pkg::*;

	localparam logic [31:0] BASE = 32'h0000_1000;
	localparam logic [7:0]  PID  = 8'h3c; // Arbitrary identification value.
	localparam logic [5:0]  RW_OFF[4] = '{OFF_CONTROL_ONE, OFF_CONTROL_TWO,
		OFF_CONTROL_THREE, OFF_CONTROL_FOUR};
	localparam logic [7:0]  RW_MSK[4] = '{MASK_CONTROL_ONE, MASK_CONTROL_TWO,
		MASK_CONTROL_THR, MASK_CONTROL_FOU};

	logic           mclk;
	logic           rst_b;
	logic [2:0]     ev;
	logic [31:0]    base_addr;
	logic [31:0]    bus_rdata;
	logic           bus_rvalid;
	logic           count_zero;
	logic [23:0]    current_count;
	logic           fifo_push;
	logic           fifo_pop;
	logic [7:0]     fifo_wdata;
	logic           cmd_push;
	logic [7:0]     cmd_wdata;
	logic           int_status_read;
	logic [47:0]    r48;
	logic [7:0]     d;
	logic [15:0]    lfsr = 16'h9745;
	logic [31:0]    exp_q[$];
	scr_bus_req_t   bus_req;
	scr_core_stat_t cs;
	scr_cfg_t       cfg;
	int             error_cnt = 0;
	int             num_checks = 0;

	scr_regs #(.PART_ID(PID)) dut (.mclk, .rst_b, .base_addr, .bus_req, .bus_rdata,
		.bus_rvalid, .core_stat(cs), .dma_start(ev[2]), .dec_word(ev[1]), .dec_byte(ev[0]),
		.count_zero, .current_count, .cfg, .fifo_push, .fifo_pop, .fifo_wdata,
		.cmd_push, .cmd_wdata, .int_status_read);
	scr_host_model host (.mclk, .req(bus_req));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ==========================================================================
	// Helpers.
	// ==========================================================================
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] o, input logic [7:0] v);
		host.acc(1'b1, BASE + {26'h0, o}, v, 4'h1);
	endtask

	// The note goes in before the cycle, so the watcher always finds it.
	task automatic rd(input logic [5:0] o, input logic [7:0] v);
		exp_q.push_back({24'h000000, v});
		host.acc(1'b0, BASE + {26'h0, o}, 8'h00, 4'h1);
	endtask

	task automatic evt(input logic [2:0] e);
		@(posedge mclk) #1;
		ev = e;
		@(posedge mclk) #1;
		ev = 3'h0;
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// An answer with no note behind it counts as a mismatch against unknown.
	always @(posedge mclk) begin
		if (bus_rvalid === 1'b1)
			chk(bus_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
	end

	initial begin
		#100000;
		error_cnt++;
		end_of_test();
	end

	// ==========================================================================
	// Scenarios.
	// ==========================================================================
	initial begin
		rst_b = 1'b0;
		ev = 3'h0;
		cs = '0;
		base_addr = BASE;
		repeat (3) @(posedge mclk);
		#1 rst_b = 1'b1;
		chk(cfg, scr_cfg_t'{sync_period: 5'h05, clock_conv: 3'h2, default: '0});
		rd(OFF_COUNT_HIGH, PID);
		repeat (4) begin
			r48 = {rnd(), rnd(), rnd()};
			cs = r48[43:0];
			d = 8'(rnd());
			rd(OFF_STATUS_ID, cs.bus_status);
			rd(OFF_INT_TIMEOUT, cs.int_status);
			chk(int_status_read, 1'b1);
			rd(OFF_STATE_PERIOD, {4'h0, cs.sync_flag, cs.seq_state});
			rd(OFF_FIFO_OFFSET, {cs.fifo_istate, cs.fifo_count});
			rd(OFF_FIFO_PORT, cs.fifo_rdata);
			chk(fifo_pop, 1'b1);
			rd(OFF_COMMAND, cs.cmd_current);
			chk({fifo_pop, int_status_read}, 2'b00);
			wr(OFF_FIFO_PORT, d);
			chk({fifo_push, fifo_wdata}, {1'b1, d});
			wr(OFF_COMMAND, ~d);
			chk({cmd_push, cmd_wdata, fifo_push}, {1'b1, ~d, 1'b0});
			wr(OFF_STATUS_ID, d);
			chk(cfg.target_id, d[2:0]);
			wr(OFF_INT_TIMEOUT, d);
			chk(cfg.sel_timeout, d);
			wr(OFF_STATE_PERIOD, d);
			chk(cfg.sync_period, d[4:0]);
			wr(OFF_FIFO_OFFSET, d);
			chk(cfg.sync_offset_timing, d);
			wr(OFF_CLOCK_CONV, d);
			chk(cfg.clock_conv, d[2:0]);
			rd(OFF_CLOCK_CONV, 8'h00);
			for (int i = 0; i < 4; i++) begin
				wr(RW_OFF[i], d);
				rd(RW_OFF[i], d & RW_MSK[i]);
			end
			wr(OFF_RESERVED_A, ~d);
			rd(OFF_RESERVED_A, 8'h00);
			wr(OFF_RESERVED_B, ~d);
			rd(OFF_RESERVED_B, 8'h00);
			host.acc(1'b1, (BASE ^ 32'h0000_0100) + 32'h10, ~d, 4'h1);
			chk(cfg.target_id, d[2:0]);
			host.acc(1'b1, BASE + 32'h10, ~d, 4'he);
			chk(cfg.target_id, d[2:0]);
			host.acc(1'b0, BASE ^ 32'h0000_0040, 8'h00, 4'h1);
		end
		wr(OFF_CONTROL_TWO, 8'h00);
		wr(OFF_COUNT_LOW, 8'h34);
		wr(OFF_COUNT_MID, 8'h12);
		wr(OFF_COUNT_HIGH, 8'h77);
		rd(OFF_COUNT_HIGH, PID);
		evt(3'h4);
		chk(current_count, 24'h001234);
		evt(3'h1);
		evt(3'h2);
		rd(OFF_COUNT_LOW, 8'h31);
		rd(OFF_COUNT_MID, 8'h12);
		wr(OFF_CONTROL_TWO, 8'h40);
		wr(OFF_COUNT_HIGH, 8'ha5);
		evt(3'h4);
		chk(current_count, 24'ha51234);
		rd(OFF_COUNT_HIGH, 8'ha5);
		wr(OFF_CONTROL_TWO, 8'h00);
		wr(OFF_COUNT_HIGH, 8'h77);
		wr(OFF_COUNT_LOW, 8'h01);
		wr(OFF_COUNT_MID, 8'h00);
		evt(3'h4);
		chk(current_count, 24'h000001);
		rd(OFF_COUNT_HIGH, 8'h00);
		evt(3'h2);
		chk({count_zero, current_count}, 25'h1000000);
		wr(OFF_CONTROL_TWO, 8'h40);
		evt(3'h4);
		chk(current_count, 24'ha50001);
		evt(3'h3);
		chk({count_zero, current_count}, 25'h0a4ffff);
		repeat (3) @(posedge mclk);
		chk(exp_q.size(), 0);
		end_of_test();
	end
endmodule // testbench

`default_nettype wire
